// ---- pss_pkg.sv ----
// constants and register layout for the phy status and negotiation registers
// How it works
// - basic status speed/duplex capability bits read one
// - preamble suppression status bit reads one
// - negotiation complete follows engine, zero after reset
// - jabber latches high, link latches low
// - negotiation ability and extended capability read one
// - first identifier returns identifier bits three-eighteen
// - second identifier top six: identifier bits 19-24
// - model number and silicon revision read-only
// - two-bit pause advertisement writable, reset 00
// - next page, fault advertise writable; reserved zero
// - 100 Mbps advertisement loaded from rate strap
// - 10 Mbps advertisement bits writable, reset one
// - selector field writable, resets to 00001
// - partner base page captured into read-only register
// - parallel detection fault latches high until read
// - page received latches high until read
// - local next page one; partner bits reset zero
// - message page resets one, message field 00000000001
// - host owns next page and ack2 bits
// - toggle bit shows last sent code word
package pss_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;

  localparam logic [4:0] REG_BSR = 5'h01;
  localparam logic [4:0] REG_ID1 = 5'h02;
  localparam logic [4:0] REG_ID2 = 5'h03;
  localparam logic [4:0] REG_ADV = 5'h04;
  localparam logic [4:0] REG_LPA = 5'h05;
  localparam logic [4:0] REG_EXP = 5'h06;
  localparam logic [4:0] REG_NPT = 5'h07;

  // basic status bit positions
  localparam int BSR_100FD = 14;
  localparam int BSR_100HD = 13;
  localparam int BSR_10FD = 12;
  localparam int BSR_10HD = 11;
  localparam int BSR_NOPRE = 6;
  localparam int BSR_ANDONE = 5;
  localparam int BSR_RFAULT = 4;
  localparam int BSR_ANABLE = 3;
  localparam int BSR_LINK = 2;
  localparam int BSR_JABBER = 1;
  localparam int BSR_EXTCAP = 0;

  // second identifier fields
  localparam int ID2_OUI_LSB = 10;
  localparam int ID2_MODEL_LSB = 4;
  localparam int ID2_REV_LSB = 0;

  // advertisement fields
  localparam int ADV_100FD = 8;
  localparam int ADV_100HD = 7;
  localparam logic [15:0] ADV_WMASK = 16'hADFF;
  localparam logic [15:0] ADV_RST = 16'h0061;

  // expansion bit positions
  localparam int EXP_PDF = 4;
  localparam int EXP_LPNP = 3;
  localparam int EXP_NPABLE = 2;
  localparam int EXP_PAGERX = 1;
  localparam int EXP_LPAN = 0;

  // next page transmit
  localparam int NPT_TOGGLE = 11;
  localparam logic [15:0] NPT_WMASK = 16'hB7FF;
  localparam logic [15:0] NPT_RST = 16'h2001;

  localparam logic [15:0] LPA_RST = 16'h0001;
  localparam logic [15:0] ZERO16 = 16'h0000;
endpackage : pss_pkg

// ---- pss_sync.sv ----
// two-stage synchroniser for a level arriving from a pin
`timescale 1ns/1ps
`default_nettype none
module pss_sync
(
  input wire logic ref_clk, // system clock
  input wire logic async_in, // level from outside the domain
  output var logic sync_out // level safe to read
);
  logic meta_r;

  // no reset: a strap must be tracked while reset is still asserted
  always_ff @(posedge ref_clk)
  begin
    meta_r <= async_in;
    sync_out <= meta_r;
  end
endmodule : pss_sync
`default_nettype wire

// ---- pss_latch.sv ----
// one latched status bit, latch-high or latch-low, cleared by a read
`timescale 1ns/1ps
`default_nettype none
module pss_latch #(
  parameter bit LATCH_LOW = 1'b0 // 1: bit holds low after a drop
)
(
  input wire logic ref_clk, // system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic cond, // live condition
  input wire logic rd_clr, // owning register read this cycle
  output var logic state_r // latched value
);
  logic state_nxt;

  always_comb
  begin
    // the live condition beats the read clear, so nothing is lost
    if (LATCH_LOW)
      state_nxt = cond & (state_r | rd_clr);
    else
      state_nxt = cond | (state_r & ~rd_clr);
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      state_r <= 1'b0;
    else
      state_r <= state_nxt;
  end

  // a read in the same cycle must not matter: the condition wins
  a_latch_hold: assert property (
    @(posedge ref_clk) disable iff (!rst_n)
    (cond != LATCH_LOW) |=> (state_r == !LATCH_LOW))
    else $error("latched bit did not follow its condition");
endmodule : pss_latch
`default_nettype wire

// ---- pss_regs.sv ----
// status, identity and negotiation register group of the transceiver
`timescale 1ns/1ps
`default_nettype none
module pss_regs #(
  parameter logic [15:0] ID_HIGH = 16'h5A5A, // arbitrary value
  parameter logic [5:0] ID_OUI_LOW = 6'h2A, // arbitrary value
  parameter logic [5:0] ID_MODEL = 6'h15, // arbitrary value
  parameter logic [3:0] ID_REV = 4'h3 // arbitrary value
)
(
  input wire logic ref_clk, // 20 MHz system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic rate_strap, // rate strapping pin level
  input wire logic [pss_pkg::ADDR_W-1:0] reg_addr, // register number
  input wire logic reg_rd, // read strobe, one cycle
  input wire logic reg_wr, // write strobe, one cycle
  input wire logic [pss_pkg::DATA_W-1:0] reg_wdata, // write data
  output var logic [pss_pkg::DATA_W-1:0] reg_rdata, // read data
  output var logic reg_rvalid, // read data valid pulse
  input wire logic an_complete, // negotiation finished, level
  input wire logic remote_fault, // remote fault seen, level
  input wire logic jabber, // jabber seen, level
  input wire logic link_up, // link monitor level
  input wire logic par_fault, // parallel detection fault, level
  input wire logic page_rcvd, // new page from partner, pulse
  input wire logic lp_page_valid, // partner base page valid, pulse
  input wire logic [pss_pkg::DATA_W-1:0] lp_page, // partner base page
  input wire logic lp_an_able, // partner can negotiate, level
  input wire logic lp_np_able, // partner has next pages, level
  input wire logic lcw_sent, // code word sent, pulse
  input wire logic lcw_toggle, // toggle of the sent word
  output var logic [pss_pkg::DATA_W-1:0] adv_word, // advertised page
  output var logic [pss_pkg::DATA_W-1:0] np_word // next page to send
);
  import pss_pkg::*;

  logic [15:0] adv_r;
  logic [15:0] np_r;
  logic [15:0] lpa_r;
  logic lp_an_r;
  logic lp_np_r;
  logic toggle_r;
  logic an_done_r;
  logic strap_pend_r;
  logic strap_s;
  logic rf_lat;
  logic jab_lat;
  logic link_lat;
  logic pdf_lat;
  logic prx_lat;
  logic rd_bsr;
  logic rd_exp;
  logic wr_adv;
  logic wr_npt;
  logic [15:0] bsr_val;
  logic [15:0] exp_val;
  logic [15:0] rdata_nxt;

  assign rd_bsr = reg_rd && (reg_addr == REG_BSR);
  assign rd_exp = reg_rd && (reg_addr == REG_EXP);
  assign wr_adv = reg_wr && (reg_addr == REG_ADV);
  assign wr_npt = reg_wr && (reg_addr == REG_NPT);

  pss_sync u_strap_sync
  (
    .ref_clk(ref_clk),
    .async_in(rate_strap),
    .sync_out(strap_s)
  );

  pss_latch #(.LATCH_LOW(1'b0)) u_rf_lat
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .cond(remote_fault),
    .rd_clr(rd_bsr),
    .state_r(rf_lat)
  );

  pss_latch #(.LATCH_LOW(1'b0)) u_jab_lat
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .cond(jabber),
    .rd_clr(rd_bsr),
    .state_r(jab_lat)
  );

  pss_latch #(.LATCH_LOW(1'b1)) u_link_lat
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .cond(link_up),
    .rd_clr(rd_bsr),
    .state_r(link_lat)
  );

  pss_latch #(.LATCH_LOW(1'b0)) u_pdf_lat
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .cond(par_fault),
    .rd_clr(rd_exp),
    .state_r(pdf_lat)
  );

  pss_latch #(.LATCH_LOW(1'b0)) u_prx_lat
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .cond(page_rcvd),
    .rd_clr(rd_exp),
    .state_r(prx_lat)
  );

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      an_done_r <= 1'b0;
    else
      an_done_r <= an_complete;
  end

  // advertisement: strap sampled on the first cycle after release
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      adv_r <= ADV_RST;
      strap_pend_r <= 1'b1;
    end
    else
    begin
      strap_pend_r <= 1'b0;
      if (wr_adv)
        adv_r <= reg_wdata & ADV_WMASK;
      else if (strap_pend_r)
      begin
        adv_r[ADV_100FD] <= strap_s;
        adv_r[ADV_100HD] <= strap_s;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      np_r <= NPT_RST;
    else if (wr_npt)
      np_r <= reg_wdata & NPT_WMASK;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
      toggle_r <= 1'b0;
    else if (lcw_sent)
      toggle_r <= lcw_toggle;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      lpa_r <= LPA_RST;
      lp_an_r <= 1'b0;
      lp_np_r <= 1'b0;
    end
    else
    begin
      if (lp_page_valid)
        lpa_r <= lp_page;
      lp_an_r <= lp_an_able;
      lp_np_r <= lp_np_able;
    end
  end

  always_comb
  begin
    bsr_val = ZERO16;
    bsr_val[BSR_100FD] = 1'b1;
    bsr_val[BSR_100HD] = 1'b1;
    bsr_val[BSR_10FD] = 1'b1;
    bsr_val[BSR_10HD] = 1'b1;
    bsr_val[BSR_NOPRE] = 1'b1;
    bsr_val[BSR_ANDONE] = an_done_r;
    bsr_val[BSR_RFAULT] = rf_lat;
    bsr_val[BSR_ANABLE] = 1'b1;
    bsr_val[BSR_LINK] = link_lat;
    bsr_val[BSR_JABBER] = jab_lat;
    bsr_val[BSR_EXTCAP] = 1'b1;
    exp_val = ZERO16;
    exp_val[EXP_PDF] = pdf_lat;
    exp_val[EXP_LPNP] = lp_np_r;
    exp_val[EXP_NPABLE] = 1'b1;
    exp_val[EXP_PAGERX] = prx_lat;
    exp_val[EXP_LPAN] = lp_an_r;
  end

  always_comb
  begin
    case (reg_addr)
      REG_BSR: rdata_nxt = bsr_val;
      REG_ID1: rdata_nxt = ID_HIGH;
      REG_ID2: rdata_nxt = {ID_OUI_LOW, ID_MODEL, ID_REV};
      REG_ADV: rdata_nxt = adv_r;
      REG_LPA: rdata_nxt = lpa_r;
      REG_EXP: rdata_nxt = exp_val;
      REG_NPT: rdata_nxt = np_r | ({15'h0000, toggle_r} << NPT_TOGGLE);
      default: rdata_nxt = ZERO16;
    endcase
  end

  // read value taken before the clear lands, so an event is seen once
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      reg_rdata <= ZERO16;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
        reg_rdata <= rdata_nxt;
    end
  end

  assign adv_word = adv_r;
  assign np_word = np_r;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_read_bsr;
    reg_rd && (reg_addr == REG_BSR);
  endsequence

  sequence s_page_then_quiet;
    page_rcvd ##1 (!rd_exp) [*2];
  endsequence

  a_fixed_caps: assert property (s_read_bsr |=>
    reg_rvalid && reg_rdata[BSR_100FD] &&
    reg_rdata[BSR_100HD] && reg_rdata[BSR_10FD] &&
    reg_rdata[BSR_10HD] && reg_rdata[BSR_NOPRE] &&
    reg_rdata[BSR_ANABLE] && reg_rdata[BSR_EXTCAP])
    else $error("fixed capability bits wrong");

  a_done_read: assert property (s_read_bsr ##0 an_done_r |=>
    reg_rdata[BSR_ANDONE])
    else $error("negotiation complete not reported");

  // the gap cycle proves the bit is held, not just passed through
  a_rf_read: assert property (
    remote_fault ##1 !rd_bsr ##1 s_read_bsr |=> reg_rdata[BSR_RFAULT])
    else $error("remote fault lost before read");

  a_link_drop: assert property (!link_up ##1 s_read_bsr |=>
    !reg_rdata[BSR_LINK])
    else $error("link drop not latched low");

  a_jab_read: assert property (jabber ##1 s_read_bsr |=>
    reg_rdata[BSR_JABBER])
    else $error("jabber not latched high");

  a_id_values: assert property (
    reg_rd && (reg_addr == REG_ID2) |=>
    reg_rdata == {ID_OUI_LOW, ID_MODEL, ID_REV})
    else $error("second identifier wrong");

  a_id_high: assert property (reg_rd && (reg_addr == REG_ID1) |=>
    reg_rdata == ID_HIGH)
    else $error("first identifier wrong");

  a_adv_reset: assert property ($rose(rst_n) |->
    (adv_r & ~(16'h0001 << ADV_100FD) & ~(16'h0001 << ADV_100HD)) == ADV_RST)
    else $error("advertisement reset value wrong");

  a_adv_reserved: assert property ((adv_r & ~ADV_WMASK) == ZERO16)
    else $error("advertisement reserved bits set");

  a_strap_load: assert property (strap_pend_r && !wr_adv |=>
    adv_r[ADV_100FD] == $past(strap_s) &&
    adv_r[ADV_100HD] == $past(strap_s))
    else $error("rate strap not loaded");

  a_lp_capture: assert property (lp_page_valid |=>
    lpa_r == $past(lp_page))
    else $error("partner page not captured");

  a_page_held: assert property (s_page_then_quiet |-> prx_lat)
    else $error("page received bit dropped");

  a_pdf_held: assert property (par_fault ##1 rd_exp |=>
    reg_rdata[EXP_PDF] && reg_rdata[EXP_NPABLE])
    else $error("parallel fault not latched");

  a_np_reset: assert property ($rose(rst_n) |-> np_r == NPT_RST)
    else $error("next page reset value wrong");

  a_toggle_read: assert property (lcw_sent ##1 !lcw_sent ##1
    (reg_rd && reg_addr == REG_NPT && !lcw_sent) |=>
    reg_rdata[NPT_TOGGLE] == $past(lcw_toggle, 3))
    else $error("toggle bit does not follow sent word");
endmodule : pss_regs
`default_nettype wire

// ---- pss_engine.sv ----
// behavioural negotiation engine and link monitor for the status inputs
`timescale 1ns/1ps
`default_nettype none
module pss_engine
(
  input wire logic ref_clk, // system clock
  output var logic an_complete, // negotiation done
  output var logic remote_fault, // remote fault level
  output var logic jabber, // jabber level
  output var logic link_up, // link level
  output var logic par_fault, // parallel detect fault
  output var logic page_rcvd, // page arrival pulse
  output var logic lp_page_valid, // base page strobe
  output var logic [15:0] lp_page, // partner base page
  output var logic lp_an_able, // partner negotiates
  output var logic lp_np_able, // partner has next pages
  output var logic lcw_sent, // code word sent pulse
  output var logic lcw_toggle // toggle of sent word
);
  initial
  begin
    {an_complete, remote_fault, jabber, link_up, par_fault} = 5'h00;
    {page_rcvd, lp_page_valid, lp_an_able, lp_np_able} = 4'h0;
    {lcw_sent, lcw_toggle} = 2'h0;
    lp_page = 16'h0000;
  end
  // v = {an_complete, remote_fault, jabber, link_up, par_fault}
  task automatic set_levels(input logic [4:0] v);
    @(posedge ref_clk);
    #1;
    {an_complete, remote_fault, jabber, link_up, par_fault} = v;
  endtask : set_levels
  // word is only meaningful under the strobe, so it is spoiled after
  // able = {lp_np_able, lp_an_able}, levels that stay after the page
  task automatic send_page(input logic [15:0] w, input logic [1:0] able);
    @(posedge ref_clk);
    #1;
    lp_page = w;
    {lp_page_valid, page_rcvd} = 2'h3;
    {lp_np_able, lp_an_able} = able;
    @(posedge ref_clk);
    #1;
    lp_page = ~w;
    {lp_page_valid, page_rcvd} = 2'h0;
  endtask : send_page
  task automatic send_lcw(input logic t);
    @(posedge ref_clk);
    #1;
    lcw_sent = 1'b1;
    lcw_toggle = t;
    @(posedge ref_clk);
    #1;
    lcw_sent = 1'b0;
    lcw_toggle = ~t;
  endtask : send_lcw
endmodule : pss_engine
`default_nettype wire

// ---- phy_status_autoneg_registers_bench.sv ----
// self-checking bench for the status and negotiation register group
`timescale 1ns/1ps
`default_nettype none
module phy_status_autoneg_registers_bench;
  import pss_pkg::*;
  logic ref_clk, rst_n, rate_strap, reg_rd, reg_wr, reg_rvalid;
  logic an_complete, remote_fault, jabber, link_up, par_fault;
  logic page_rcvd, lp_page_valid, lp_an_able, lp_np_able;
  logic lcw_sent, lcw_toggle;
  logic [4:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, lp_page, adv_word, np_word;
  int err_count = 0;
  int total_checks = 0;

  pss_regs u_pss_regs (.ref_clk(ref_clk), .rst_n(rst_n),
    .rate_strap(rate_strap), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .an_complete(an_complete),
    .remote_fault(remote_fault), .jabber(jabber), .link_up(link_up),
    .par_fault(par_fault), .page_rcvd(page_rcvd),
    .lp_page_valid(lp_page_valid), .lp_page(lp_page),
    .lp_an_able(lp_an_able), .lp_np_able(lp_np_able),
    .lcw_sent(lcw_sent), .lcw_toggle(lcw_toggle),
    .adv_word(adv_word), .np_word(np_word));
  pss_engine u_pss_engine (.ref_clk(ref_clk), .an_complete(an_complete),
    .remote_fault(remote_fault), .jabber(jabber), .link_up(link_up),
    .par_fault(par_fault), .page_rcvd(page_rcvd),
    .lp_page_valid(lp_page_valid), .lp_page(lp_page),
    .lp_an_able(lp_an_able), .lp_np_able(lp_np_able),
    .lcw_sent(lcw_sent), .lcw_toggle(lcw_toggle));

  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  // answer lands exactly one cycle after the strobe edge
  task automatic rdc(input logic [4:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_rd = 1'b0;
    check({15'h0000, reg_rvalid}, 16'h0001);
    check(reg_rdata, exp);
  endtask : rdc
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_wr = 1'b0;
  endtask : wr
  // strap fills its synchroniser over the two reset edges
  task automatic do_reset(input logic strap);
    @(posedge ref_clk);
    #1;
    rst_n = 1'b0;
    rate_strap = strap;
    repeat (2) @(posedge ref_clk);
    #1;
    check(adv_word, 16'h0061);
    check(np_word, 16'h2001);
    rst_n = 1'b1;
  endtask : do_reset
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report

  task automatic t_reset;
    rdc(REG_BSR, 16'h7849);
    rdc(REG_ID1, 16'h5A5A);
    rdc(REG_ID2, 16'hA953);
    rdc(REG_ADV, 16'h01E1);
    rdc(REG_LPA, 16'h0001);
    rdc(REG_EXP, 16'h0004);
    rdc(REG_NPT, 16'h2001);
    rdc(5'h1F, 16'h0000);
    $display("test reset done");
  endtask : t_reset
  task automatic t_write;
    wr(REG_ADV, 16'hFFFF);
    rdc(REG_ADV, 16'hADFF);
    check(adv_word, 16'hADFF);
    for (int p = 0; p < 4; p++)
    begin
      wr(REG_ADV, 16'(p) << 10);
      rdc(REG_ADV, 16'(p) << 10);
    end
    wr(REG_NPT, 16'hFFFF);
    rdc(REG_NPT, 16'hB7FF);
    check(np_word, 16'hB7FF);
    wr(REG_ID1, 16'h0000);
    rdc(REG_ID1, 16'h5A5A);
    $display("test write done");
  endtask : t_write
  task automatic t_latch;
    u_pss_engine.set_levels(5'b11110);
    u_pss_engine.set_levels(5'b10010);
    rdc(REG_BSR, 16'h787B);
    rdc(REG_BSR, 16'h786D);
    u_pss_engine.set_levels(5'b10110);
    rdc(REG_BSR, 16'h786F);
    rdc(REG_BSR, 16'h786F);
    u_pss_engine.set_levels(5'b10000);
    u_pss_engine.set_levels(5'b10010);
    rdc(REG_BSR, 16'h786B);
    rdc(REG_BSR, 16'h786D);
    u_pss_engine.set_levels(5'b00000);
    rdc(REG_BSR, 16'h7849);
    $display("test latch done");
  endtask : t_latch
  task automatic t_partner;
    u_pss_engine.set_levels(5'b00001);
    u_pss_engine.set_levels(5'b00000);
    u_pss_engine.send_page(16'hC5E1, 2'b11);
    rdc(REG_LPA, 16'hC5E1);
    rdc(REG_EXP, 16'h001F);
    rdc(REG_EXP, 16'h000D);
    u_pss_engine.send_page(16'h4DE1, 2'b01);
    rdc(REG_LPA, 16'h4DE1);
    rdc(REG_EXP, 16'h0007);
    u_pss_engine.set_levels(5'b00001);
    rdc(REG_EXP, 16'h0015);
    u_pss_engine.set_levels(5'b00000);
    rdc(REG_EXP, 16'h0015);
    rdc(REG_EXP, 16'h0005);
    u_pss_engine.send_lcw(1'b1);
    rdc(REG_NPT, 16'hBFFF);
    u_pss_engine.send_lcw(1'b0);
    rdc(REG_NPT, 16'hB7FF);
    $display("test partner done");
  endtask : t_partner
  task automatic t_strap;
    do_reset(1'b0);
    rdc(REG_ADV, 16'h0061);
    rdc(REG_NPT, 16'h2001);
    $display("test strap done");
  endtask : t_strap

  initial
  begin
    {rst_n, rate_strap, reg_rd, reg_wr} = 4'h4;
    reg_addr = 5'h00;
    reg_wdata = 16'h0000;
    do_reset(1'b1);
    t_reset();
    t_write();
    t_latch();
    t_partner();
    t_strap();
    final_report();
  end
  initial
  begin
    #500000;
    err_count++;
    $display("Error at %0t: run did not finish", $time);
    final_report();
  end
endmodule : phy_status_autoneg_registers_bench
`default_nettype wire
